// ==== src/accel_mode_regs.vh ====
`ifndef ACCEL_MODE_REGS_VH
`define ACCEL_MODE_REGS_VH

// Register offsets on the serial port
`define REG_OUT_X_MSB 8'h00
`define REG_OUT_X_LSB 8'h01
`define REG_OUT_Y_MSB 8'h02
`define REG_OUT_Y_LSB 8'h03
`define REG_OUT_Z_MSB 8'h04
`define REG_OUT_Z_LSB 8'h05
`define REG_SYS_STATE 8'h0B
`define REG_RANGE_CFG 8'h0E
`define REG_CTRL1 8'h2A
`define REG_CTRL2 8'h2B

// Field positions
`define CTRL1_ACTIVE_BIT 0
`define CTRL2_AUTO_SLEEP_BIT 2
`define CTRL2_SELF_TEST_BIT 7

// Reset values
`define RANGE_CFG_RST 2'h0
`define CTRL1_RST 8'h00
`define CTRL2_RST 8'h00

// Full-scale range codes
`define RANGE_2G 2'h0
`define RANGE_4G 2'h1
`define RANGE_8G 2'h2

// System state encodings
`define SYS_STANDBY 2'h0
`define SYS_WAKE 2'h1
`define SYS_SLEEP 2'h2

// Serial slave address, arbitrary value
`define SLAVE_ADDR 7'h1D

// Timing
`define CLK_HZ 250000000
`define WAKE_ODR_HZ 800
`define SLEEP_ODR_HZ 50
`define WAKE_PERIOD_CYC (`CLK_HZ / `WAKE_ODR_HZ)
`define SLEEP_PERIOD_CYC (`CLK_HZ / `SLEEP_ODR_HZ)
`define IDLE_SAMPLES 8'h08
`define CNT_W 24

`endif

// ==== src/pin_sync.v ====
`timescale 1ns/10ps
module pin_sync
#(
  parameter RESET_VAL = 1'b0
)
(
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Pin and filtered level
  input wire pin,
  output reg level
);

  reg s1;
  reg s2;
  reg s3;

  // A change counts once the second and third stages agree
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      level <= RESET_VAL;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        level <= s3;
    end
  end

endmodule

// ==== src/axis_scaler.v ====
`timescale 1ns/10ps
`include "accel_mode_regs.vh"
module axis_scaler
(
  // Raw sense value, 4096 counts per g
  input wire [15:0] raw,
  input wire [15:0] test_force,
  // Controls
  input wire self_test,
  input wire [1:0] range,
  // Scaled signed 12-bit sample
  output reg [11:0] sample
);

  reg [16:0] sum;
  reg [16:0] shifted;

  // Right shift from 4096 counts per g down to the selected sensitivity
  function [2:0] range_shift;
    input [1:0] r;
    begin
      case (r)
        `RANGE_4G: range_shift = 3'h3;
        `RANGE_8G: range_shift = 3'h4;
        default: range_shift = 3'h2;
      endcase
    end
  endfunction

  always @*
  begin
    sum = {raw[15], raw} + (self_test ? {test_force[15], test_force} : 17'h00000);
    shifted = $signed(sum) >>> range_shift(range);
    if ($signed(shifted) > $signed(17'h007FF))
      sample = 12'h7FF;
    else if ($signed(shifted) < $signed(17'h1F800))
      sample = 12'h800;
    else
      sample = shifted[11:0];
  end

endmodule

// ==== src/accel_system_mode_readout.v ====
// Overview of operation
// - Device never holds the serial clock low; master alone sets clock timing.
// - Sensitivity is 1024, 512 or 256 counts per g at 2, 4, 8 g.
// - Samples sit from address zero as two's complement, zero g mid-range.
// - Self-test output is measured acceleration plus test force, scaled alike.
// - Off state: everything shut down, no reply to any bus traffic.
// - Standby: digital only, analog and sampling stopped, registers still served.
// - Active: analog and digital enabled, sampling runs, bus still served.
// - Active to standby keeps every register unchanged.
// - Standby to active resets a chosen register subset, others kept.
// - Sleep and wake are active sub-states; sampling continues in both.
`timescale 1ns/10ps
`include "accel_mode_regs.vh"
module accel_system_mode_readout
#(
  parameter WAKE_PERIOD = `WAKE_PERIOD_CYC,
  parameter SLEEP_PERIOD = `SLEEP_PERIOD_CYC
)
(
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Supply monitor pin
  input wire power_good,
  // Serial bus pins
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // Analog front end samples
  input wire [15:0] raw_x,
  input wire [15:0] raw_y,
  input wire [15:0] raw_z,
  input wire [15:0] test_force_x,
  input wire [15:0] test_force_y,
  input wire [15:0] test_force_z,
  input wire wake_event,
  // Mode outputs
  output reg analog_en,
  output reg sample_strobe,
  output reg self_test_en,
  output reg [1:0] system_state_field
);

  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_ACK_A = 3'h2;
  localparam S_PTR = 3'h3;
  localparam S_ACK_W = 3'h4;
  localparam S_WDATA = 3'h5;
  localparam S_RDATA = 3'h6;
  localparam S_ACK_R = 3'h7;

  wire [2:0] pins_raw;
  wire [2:0] pins;
  wire scl = pins[0];
  wire sda = pins[1];
  wire pwr = pins[2];
  wire [47:0] raw_all = {raw_z, raw_y, raw_x};
  wire [47:0] force_all = {test_force_z, test_force_y, test_force_x};
  wire [35:0] scaled;
  wire [7:0] rd_byte;
  reg scl_prev;
  reg sda_prev;
  reg [2:0] state;
  reg [2:0] bit_cnt;
  reg byte_done;
  reg rw;
  reg [7:0] shreg;
  reg [7:0] tx;
  reg [7:0] ptr;
  reg [1:0] range_cfg;
  reg [7:0] ctrl1;
  reg [7:0] ctrl2;
  reg [35:0] out_data;
  reg [`CNT_W-1:0] div_cnt;
  reg [7:0] idle_cnt;
  reg [1:0] next_state_field;
  assign pins_raw = {power_good, sda_in, scl_in};

  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1)
    begin : g_sync
      pin_sync #(.RESET_VAL(i == 2 ? 1'b0 : 1'b1)) u_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .pin(pins_raw[i]),
        .level(pins[i])
      );
    end
    for (i = 0; i < 3; i = i + 1)
    begin : g_axis
      axis_scaler u_scale (
        .raw(raw_all[16*i+15:16*i]),
        .test_force(force_all[16*i+15:16*i]),
        .self_test(ctrl2[`CTRL2_SELF_TEST_BIT]),
        .range(range_cfg),
        .sample(scaled[12*i+11:12*i])
      );
    end
  endgenerate

  // Register read decode
  function [7:0] reg_read;
    input [7:0] a;
    begin
      case (a)
        `REG_OUT_X_MSB: reg_read = out_data[11:4];
        `REG_OUT_X_LSB: reg_read = {out_data[3:0], 4'h0};
        `REG_OUT_Y_MSB: reg_read = out_data[23:16];
        `REG_OUT_Y_LSB: reg_read = {out_data[15:12], 4'h0};
        `REG_OUT_Z_MSB: reg_read = out_data[35:28];
        `REG_OUT_Z_LSB: reg_read = {out_data[27:24], 4'h0};
        `REG_SYS_STATE: reg_read = {6'h00, system_state_field};
        `REG_RANGE_CFG: reg_read = {6'h00, range_cfg};
        `REG_CTRL1: reg_read = ctrl1;
        `REG_CTRL2: reg_read = ctrl2;
        default: reg_read = 8'h00;
      endcase
    end
  endfunction
  assign rd_byte = reg_read(ptr);
  wire scl_rise = scl & ~scl_prev;
  wire scl_fall = ~scl & scl_prev;
  wire bus_start = scl & scl_prev & sda_prev & ~sda;
  wire bus_stop = scl & scl_prev & ~sda_prev & sda;

  // Serial slave and writable registers
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      state <= S_IDLE;
      bit_cnt <= 3'h0;
      byte_done <= 1'b0;
      rw <= 1'b0;
      shreg <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      range_cfg <= `RANGE_CFG_RST;
      ctrl1 <= `CTRL1_RST;
      ctrl2 <= `CTRL2_RST;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      scl_oe <= 1'b0;
      scl_out <= 1'b0;
    end
    else if (!pwr)
    begin
      // Powered off: contents lost and the bus is ignored
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      state <= S_IDLE;
      ptr <= 8'h00;
      range_cfg <= `RANGE_CFG_RST;
      ctrl1 <= `CTRL1_RST;
      ctrl2 <= `CTRL2_RST;
      sda_oe <= 1'b0;
    end
    else
    begin
      scl_prev <= scl;
      sda_prev <= sda;
      scl_oe <= 1'b0;
      if (bus_start)
      begin
        state <= S_ADDR;
        bit_cnt <= 3'h0;
        byte_done <= 1'b0;
        sda_oe <= 1'b0;
      end
      else if (bus_stop)
      begin
        state <= S_IDLE;
        sda_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (state == S_ADDR || state == S_PTR || state == S_WDATA)
        begin
          shreg <= {shreg[6:0], sda};
          bit_cnt <= bit_cnt + 3'h1;
          byte_done <= (bit_cnt == 3'h7);
        end
        else if (state == S_ACK_R && sda)
          state <= S_IDLE;
      end
      else if (scl_fall)
      begin
        case (state)
          S_ADDR:
            if (byte_done)
            begin
              if (shreg[7:1] == `SLAVE_ADDR)
              begin
                rw <= shreg[0];
                sda_oe <= 1'b1;
                state <= S_ACK_A;
              end
              else
                state <= S_IDLE;
            end
          S_ACK_A, S_ACK_R: // rw stays set through a read
            if (rw)
            begin
              tx <= rd_byte;
              sda_oe <= ~rd_byte[7];
              bit_cnt <= 3'h0;
              state <= S_RDATA;
            end
            else
            begin
              sda_oe <= 1'b0;
              state <= S_PTR;
            end
          S_PTR:
            if (byte_done)
            begin
              ptr <= shreg;
              sda_oe <= 1'b1;
              state <= S_ACK_W;
            end
          S_WDATA:
            if (byte_done)
            begin
              case (ptr)
                `REG_RANGE_CFG: range_cfg <= shreg[1:0];
                `REG_CTRL1: ctrl1 <= shreg;
                `REG_CTRL2: ctrl2 <= shreg;
                default: ;
              endcase
              ptr <= ptr + 8'h01;
              sda_oe <= 1'b1;
              state <= S_ACK_W;
            end
          S_ACK_W:
          begin
            sda_oe <= 1'b0;
            state <= S_WDATA;
          end
          S_RDATA:
            if (bit_cnt == 3'h7)
            begin
              sda_oe <= 1'b0;
              ptr <= ptr + 8'h01;
              state <= S_ACK_R;
            end
            else
            begin
              tx <= {tx[6:0], 1'b0};
              sda_oe <= ~tx[6];
              bit_cnt <= bit_cnt + 3'h1;
            end
          default:
            sda_oe <= 1'b0;
        endcase
      end
    end
  end

  // Next system state
  always @*
  begin
    next_state_field = system_state_field;
    if (!ctrl1[`CTRL1_ACTIVE_BIT])
      next_state_field = `SYS_STANDBY;
    else if (system_state_field == `SYS_STANDBY)
      next_state_field = `SYS_WAKE;
    else if (wake_event)
      next_state_field = `SYS_WAKE;
    else if (sample_strobe && ctrl2[`CTRL2_AUTO_SLEEP_BIT] && idle_cnt == `IDLE_SAMPLES - 8'h01)
      next_state_field = `SYS_SLEEP;
  end

  // Mode control, sample clock and output data
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      system_state_field <= `SYS_STANDBY;
      analog_en <= 1'b0;
      sample_strobe <= 1'b0;
      self_test_en <= 1'b0;
      div_cnt <= {`CNT_W{1'b0}};
      idle_cnt <= 8'h00;
      out_data <= 36'h000000000;
    end
    else if (!pwr)
    begin
      system_state_field <= `SYS_STANDBY;
      analog_en <= 1'b0;
      sample_strobe <= 1'b0;
      self_test_en <= 1'b0;
      div_cnt <= {`CNT_W{1'b0}};
      idle_cnt <= 8'h00;
      out_data <= 36'h000000000;
    end
    else
    begin
      system_state_field <= next_state_field;
      analog_en <= (next_state_field != `SYS_STANDBY);
      self_test_en <= ctrl2[`CTRL2_SELF_TEST_BIT] && (next_state_field != `SYS_STANDBY);
      sample_strobe <= 1'b0;
      if (system_state_field == `SYS_STANDBY)
      begin
        // Sampling clock held; data kept on entry to standby
        div_cnt <= {`CNT_W{1'b0}};
        idle_cnt <= 8'h00;
        if (next_state_field != `SYS_STANDBY)
          out_data <= 36'h000000000;
      end
      else
      begin
        if (div_cnt >= ((system_state_field == `SYS_SLEEP) ? SLEEP_PERIOD - 1 : WAKE_PERIOD - 1))
        begin
          div_cnt <= {`CNT_W{1'b0}};
          sample_strobe <= (next_state_field != `SYS_STANDBY);
        end
        else
          div_cnt <= div_cnt + {{(`CNT_W-1){1'b0}}, 1'b1};
        if (sample_strobe)
          out_data <= scaled;
        if (wake_event || system_state_field == `SYS_SLEEP)
          idle_cnt <= 8'h00;
        else if (sample_strobe && idle_cnt != `IDLE_SAMPLES - 8'h01)
          idle_cnt <= idle_cnt + 8'h01;
      end
    end
  end

endmodule

// ==== tb/i2c_host_model.sv ====
`timescale 1ns/10ps
module i2c_host_model
(
  // Clock and bus
  input wire ref_clk,
  input wire sda,
  output reg scl_drv,
  output reg sda_drv
);
  initial
  begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // Host alone paces the clock, 10 cycles a phase
  task hc;
    repeat (10) @(negedge ref_clk);
  endtask
  task start;
  begin
    sda_drv = 1'b1;
    hc;
    scl_drv = 1'b1;
    hc;
    sda_drv = 1'b0;
    hc;
    scl_drv = 1'b0;
    hc;
  end
  endtask
  task stop;
  begin
    sda_drv = 1'b0;
    hc;
    scl_drv = 1'b1;
    hc;
    sda_drv = 1'b1;
    hc;
  end
  endtask
  // Send d (FF to listen), then ack bit a; q is what the line showed
  task xfer(input [7:0] d, input a, output [7:0] q, output r);
    integer k;
  begin
    for (k = 8; k >= 0; k = k - 1)
    begin
      sda_drv = (k == 0) ? a : d[k-1];
      hc;
      scl_drv = 1'b1;
      hc;
      if (k > 0)
        q[k-1] = sda;
      else
        r = sda;
      scl_drv = 1'b0;
      hc;
    end
  end
  endtask
endmodule

// ==== tb/accel_mode_checker.sv ====
`timescale 1ns/10ps
module accel_mode_checker
(
  // Watched ports
  input wire ref_clk,
  input wire arst_n,
  input wire power_good,
  input wire scl_oe,
  input wire sda_oe,
  input wire analog_en,
  input wire sample_strobe,
  input wire self_test_en,
  input wire [1:0] system_state_field
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Pin filter plus one register stage before the off state takes hold
  sequence off_held;
    !power_good [*6];
  endsequence
  sequence strobe_pulse;
    sample_strobe ##1 !sample_strobe;
  endsequence
  scl_released_a: assert property (!scl_oe) else $error("scl driven");
  state_code_a: assert property (system_state_field != 2'h3) else $error("bad state");
  analog_mode_a: assert property (analog_en == (system_state_field != 2'h0)) else $error("analog");
  strobe_active_a: assert property (sample_strobe |-> system_state_field != 2'h0) else $error("strobe");
  strobe_pulse_a: assert property (sample_strobe |-> strobe_pulse) else $error("strobe width");
  off_silent_a: assert property (off_held |-> !sda_oe) else $error("sda in off");
  off_state_a: assert property (off_held |-> system_state_field == 2'h0 && !analog_en) else $error("off");
  test_active_a: assert property (self_test_en |-> system_state_field != 2'h0) else $error("test");
endmodule
bind accel_system_mode_readout accel_mode_checker chk_i
(
  .ref_clk(ref_clk),
  .arst_n(arst_n),
  .power_good(power_good),
  .scl_oe(scl_oe),
  .sda_oe(sda_oe),
  .analog_en(analog_en),
  .sample_strobe(sample_strobe),
  .self_test_en(self_test_en),
  .system_state_field(system_state_field)
);

// ==== tb/accel_system_mode_readout_tb.sv ====
`timescale 1ns/10ps
`include "accel_mode_regs.vh"
module accel_system_mode_readout_tb;
  reg ref_clk = 1'b0;
  reg arst_n = 1'b0;
  reg power_good = 1'b1;
  reg wake_event = 1'b0;
  reg [15:0] raw_x = 16'h1000;
  reg [15:0] raw_y = 16'hF000;
  reg [15:0] raw_z = 16'h0000;
  reg [15:0] tf = 16'h0000;
  wire scl_out, scl_oe, sda_out, sda_oe, analog_en, sample_strobe, self_test_en;
  wire [1:0] system_state_field;
  wire scl_drv, sda_drv;
  wire scl = scl_drv & ~(scl_oe & ~scl_out);
  wire sda = sda_drv & ~(sda_oe & ~sda_out);
  integer n_mismatch = 0;
  integer compares = 0;
  integer i;
  integer r;
  reg [15:0] q;
  reg ak;
  always #2 ref_clk = ~ref_clk;
  accel_system_mode_readout #(.WAKE_PERIOD(2000), .SLEEP_PERIOD(4000)) dut
  (
    .ref_clk(ref_clk), .arst_n(arst_n), .power_good(power_good),
    .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z),
    .test_force_x(tf), .test_force_y(tf), .test_force_z(tf),
    .wake_event(wake_event), .analog_en(analog_en), .sample_strobe(sample_strobe),
    .self_test_en(self_test_en), .system_state_field(system_state_field)
  );
  i2c_host_model host (.ref_clk(ref_clk), .sda(sda), .scl_drv(scl_drv), .sda_drv(sda_drv));
  task chk(input [15:0] e, input [15:0] g, input [63:0] nm);
  begin
    compares = compares + 1;
    if (g !== e)
    begin
      $display("[ERR] %0s exp %h got %h", nm, e, g);
      n_mismatch = n_mismatch + 1;
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    host.start;
    host.xfer({`SLAVE_ADDR, 1'b0}, 1'b1, q[7:0], ak);
    host.xfer(a, 1'b1, q[7:0], ak);
    host.xfer(d, 1'b1, q[7:0], ak);
    host.stop;
  end
  endtask
  // Two-byte read: q holds {first, second}
  task rd(input [7:0] a);
  begin
    host.start;
    host.xfer({`SLAVE_ADDR, 1'b0}, 1'b1, q[7:0], ak);
    host.xfer(a, 1'b1, q[7:0], ak);
    host.start;
    host.xfer({`SLAVE_ADDR, 1'b1}, 1'b1, q[15:8], ak);
    host.xfer(8'hFF, 1'b0, q[15:8], ak);
    host.xfer(8'hFF, 1'b1, q[7:0], ak);
    host.stop;
  end
  endtask
  task wstb;
  begin
    i = 0;
    while (sample_strobe !== 1'b1 && i < 9000)
    begin
      @(negedge ref_clk);
      i = i + 1;
    end
    @(negedge ref_clk);
    chk(16'h1, {15'h0, i < 9000}, "strobe");
  end
  endtask
  task t_reset;
  begin
    chk(16'h0, {14'h0, system_state_field}, "state");
    rd(`REG_SYS_STATE);
    chk(16'h0, {8'h0, q[15:8]}, "sysreg");
    wr(`REG_RANGE_CFG, 8'h01);
    chk(16'h0, {15'h0, ak}, "ack");
    rd(`REG_RANGE_CFG);
    chk(16'h1, {8'h0, q[15:8]}, "range");
    $display("t_reset done");
  end
  endtask
  task t_scale;
  begin
    for (r = 0; r < 3; r = r + 1)
    begin
      wr(`REG_CTRL1, 8'h00);
      wr(`REG_RANGE_CFG, r[7:0]);
      wr(`REG_CTRL1, 8'h01);
      chk(16'h1, {14'h0, system_state_field}, "wake");
      wstb;
      rd(`REG_OUT_X_MSB);
      chk(16'h4000 >> r, q, "x");
      rd(`REG_OUT_Y_MSB);
      chk($signed(16'hC000) >>> r, q, "y");
    end
    tf = 16'h1000;
    wr(`REG_CTRL2, 8'h80);
    chk(16'h1, {15'h0, self_test_en}, "st_en");
    wstb;
    rd(`REG_OUT_X_MSB);
    chk(16'h2000, q, "x_st");
    wr(`REG_CTRL2, 8'h00);
    wstb;
    $display("t_scale done");
  end
  endtask
  task t_retain;
  begin
    wr(`REG_CTRL1, 8'h00);
    chk(16'h0, {14'h0, system_state_field}, "stby");
    rd(`REG_RANGE_CFG);
    chk(16'h2, {8'h0, q[15:8]}, "range");
    rd(`REG_OUT_X_MSB);
    chk(16'h1000, q, "x_kept");
    wr(`REG_CTRL1, 8'h01);
    rd(`REG_OUT_X_MSB);
    chk(16'h0, q, "x_reinit");
    rd(`REG_RANGE_CFG);
    chk(16'h2, {8'h0, q[15:8]}, "range");
    $display("t_retain done");
  end
  endtask
  task t_sleep;
  begin
    wr(`REG_CTRL2, 8'h04);
    i = 0;
    while (system_state_field !== `SYS_SLEEP && i < 30000)
    begin
      @(negedge ref_clk);
      i = i + 1;
    end
    chk({14'h0, `SYS_SLEEP}, {14'h0, system_state_field}, "sleep");
    chk(16'h1, {15'h0, analog_en}, "analog");
    wstb;
    wake_event = 1'b1;
    @(negedge ref_clk);
    wake_event = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({14'h0, `SYS_WAKE}, {14'h0, system_state_field}, "wake");
    $display("t_sleep done");
  end
  endtask
  task t_off;
  begin
    power_good = 1'b0;
    repeat (10) @(negedge ref_clk);
    chk(16'h0, {14'h0, system_state_field}, "off");
    wr(`REG_CTRL1, 8'h01);
    chk(16'h1, {15'h0, ak}, "nack");
    power_good = 1'b1;
    repeat (10) @(negedge ref_clk);
    rd(`REG_RANGE_CFG);
    chk(16'h0, {8'h0, q[15:8]}, "range");
    $display("t_off done");
  end
  endtask
  task finish_test;
  begin
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  initial
  begin
    // About 90000 cycles, well above the expected run length
    #360000;
    n_mismatch = n_mismatch + 1;
    finish_test;
  end
  initial
  begin
    repeat (5) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    t_reset;
    t_scale;
    t_retain;
    t_sleep;
    t_off;
    finish_test;
  end
endmodule
